// ===== src/trmh_pkg.sv
/*
  Shared constants and types of the tag reader message handler.
  Assumes a 50 MHz APB clock and an outside parser that splits each
  received message into a ten-byte header and a body summary.
*/
package trmh_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_NS = 1_000_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned REPLY_TIMEOUT_MS = 45_000;

  // ==========================================================================
  // Message numbering
  localparam int unsigned ATTR_SLOTS = 10;
  localparam logic [3:0] ATTR_SLOTS_N = 4'ha;
  localparam logic [7:0] ATTR_ID_NONE = 8'h00;
  localparam logic [7:0] TGT_ID_NONE = 8'h00;
  localparam logic [7:0] FN_STEP = 8'h01;
  localparam logic [6:0] STRM_MAT = 7'h03;
  localparam logic [6:0] STRM_ERR = 7'h09;
  localparam logic [6:0] STRM_CTL = 7'h12;
  localparam logic [7:0] FN_ABORT = 8'h00;
  localparam logic [7:0] FN_MID_RPT = 8'h0d;
  localparam logic [7:0] FN_MID_RPT_ACK = 8'h0e;
  localparam logic [7:0] FN_DSP_WR = 8'h45;
  localparam logic [7:0] FN_ERR_DEV = 8'h01;
  localparam logic [7:0] FN_ERR_STRM = 8'h03;
  localparam logic [7:0] FN_ERR_FUNC = 8'h05;
  localparam logic [7:0] FN_ERR_DATA = 8'h07;
  localparam logic [7:0] FN_ERR_TMO = 8'h09;
  localparam logic [7:0] FN_ATTR_RD = 8'h01;
  localparam logic [7:0] FN_ATTR_WR = 8'h03;
  localparam logic [7:0] FN_DATA_RD = 8'h05;
  localparam logic [7:0] FN_DATA_WR = 8'h07;
  localparam logic [7:0] FN_MID_RD = 8'h09;
  localparam logic [7:0] FN_MID_WR = 8'h0b;
  localparam logic [7:0] FN_SUBSYS = 8'h0d;
  localparam logic [7:0] FN_SCAN = 8'h41;

  // Two-character acknowledge codes, ASCII
  localparam logic [15:0] ACK_NORMAL = 16'h4e4f;
  localparam logic [15:0] ACK_EQUIP_ERR = 16'h4545;
  localparam logic [15:0] ACK_COMM_ERR = 16'h4345;

  // ==========================================================================
  // Register map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DEVID = 12'h004;
  localparam logic [11:0] OFS_LIMIT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_COUNT = 12'h010;
  localparam int unsigned CTRL_MT_BIT = 0;
  localparam int unsigned LIM_TGT_LSB = 0;
  localparam int unsigned LIM_ATTR_LSB = 8;
  localparam int unsigned STAT_PEND_BIT = 0;
  localparam int unsigned STAT_DUE_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_LASTERR_LSB = 8;
  localparam int unsigned CNT_ERR_LSB = 0;
  localparam int unsigned CNT_TMO_LSB = 16;
  localparam logic RST_MT = 1'b0;
  localparam logic [14:0] RST_DEVID = 15'h0001;
  localparam logic [7:0] RST_TGT_MAX = 8'h01;
  localparam logic [7:0] RST_ATTR_MAX = 8'h20;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic rbit;
    logic [14:0] dev_id;
    logic wbit;
    logic [6:0] stream;
    logic [7:0] func;
    logic [7:0] ptype;
    logic [7:0] stype;
    logic [31:0] sys_bytes;
  } trmh_hdr_t;

  typedef struct packed {
    logic ok;
    logic [7:0] target;
    logic [3:0] attr_n;
    logic [ATTR_SLOTS-1:0][7:0] attr_id;
    logic seg_present;
    logic len_present;
    logic [15:0] len_value;
    logic [15:0] data_bytes;
  } trmh_body_t;

  typedef enum logic [3:0] {
    OP_ATTR_RD, OP_ATTR_WR, OP_DATA_RD, OP_DATA_WR, OP_MID_RD, OP_MID_WR,
    OP_SUBSYS, OP_SCAN, OP_DISPLAY
  } trmh_op_t;

  typedef struct packed {
    logic all_pages;
    logic from_start;
    logic whole_section;
    logic len_sets_size;
  } trmh_mode_t;

  typedef struct packed {
    trmh_op_t op;
    logic [7:0] target;
    trmh_mode_t mode;
    logic [15:0] len;
  } trmh_exec_t;

  typedef struct packed {
    trmh_hdr_t hdr;
    logic [15:0] ack;
    trmh_hdr_t offending_header;
    logic [ATTR_SLOTS-1:0] empty_slot;
    logic [7:0] item_count;
    logic [7:0] port;
  } trmh_reply_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEND} trmh_state_t;

endpackage : trmh_pkg

// ===== src/trmh_core.sv
/*
  Message-level interpreter of the tag reader: checks incoming headers,
  dispatches requests to the transponder engine, builds replies and
  error messages, and times the host reply to a material report.
  Assumes an outside parser delivers header and body summary, an outside
  engine runs operations, and an outside framer sends the reply struct.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module trmh_core #(
  parameter int unsigned TICK_CYC = trmh_pkg::TICK_CYC,
  parameter int unsigned REPLY_TIMEOUT_MS = trmh_pkg::REPLY_TIMEOUT_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire trmh_pkg::trmh_hdr_t rx_hdr,
  input wire trmh_pkg::trmh_body_t rx_body,
  output logic rx_ready,
  input wire logic mat_req,
  input wire logic [7:0] mat_port,
  output logic mat_ack,
  output logic exec_start,
  output trmh_pkg::trmh_exec_t exec_cmd,
  input wire logic exec_done,
  input wire logic [15:0] exec_ack,
  input wire logic [7:0] exec_count,
  output logic tx_valid,
  output trmh_pkg::trmh_reply_t tx_msg,
  input wire logic tx_ready
);

  // ==========================================================================
  // Declarations
  trmh_pkg::trmh_state_t state_r;
  trmh_pkg::trmh_state_t state_nxt;
  logic maint_r;
  logic [14:0] dev_id_r;
  logic [7:0] tgt_max_r;
  logic [7:0] attr_max_r;
  logic pending_r;
  logic due_r;
  trmh_pkg::trmh_hdr_t saved_hdr_r;
  logic [31:0] tick_cnt_r;
  logic [31:0] ms_cnt_r;
  logic tick;
  logic expire;
  logic want_r;
  logic [31:0] seq_r;
  logic [15:0] err_cnt_r;
  logic [15:0] tmo_cnt_r;
  logic [7:0] last_err_r;
  logic [trmh_pkg::ATTR_SLOTS-1:0] attr_unknown;
  logic take_rx;
  logic take_due;
  logic take_mat;
  logic dec_send;
  logic dec_exec;
  logic dec_err;
  logic dec_cancel;
  trmh_pkg::trmh_reply_t dec_reply;
  trmh_pkg::trmh_exec_t dec_cmd;
  trmh_pkg::trmh_hdr_t mat_hdr;
  logic tgt_ok;
  logic strm_ok;
  logic fn_ok;
  logic is_attr;
  logic apb_setup;
  logic apb_wr;
  logic [31:0] rd_data;
  logic rd_hit;

  // ==========================================================================
  // Request arbitration: received message first, then timeout, then report
  assign take_rx = (state_r == trmh_pkg::ST_IDLE) && rx_valid && rx_ready;
  assign take_due = (state_r == trmh_pkg::ST_IDLE) && !take_rx && due_r;
  assign take_mat = (state_r == trmh_pkg::ST_IDLE) && !take_rx && !due_r && mat_req;

  // Unknown attribute per requested slot
  generate
    for (genvar g = 0; g < trmh_pkg::ATTR_SLOTS; g++) begin : g_attr
      assign attr_unknown[g] = (4'(g) < rx_body.attr_n) &&
        ((rx_body.attr_id[g] == trmh_pkg::ATTR_ID_NONE) ||
         (rx_body.attr_id[g] > attr_max_r));
    end
  endgenerate

  // Antenna target known when within configured head count
  assign tgt_ok = (rx_body.target != trmh_pkg::TGT_ID_NONE) && (rx_body.target <= tgt_max_r);
  assign strm_ok = (rx_hdr.stream == trmh_pkg::STRM_MAT) || (rx_hdr.stream == trmh_pkg::STRM_CTL);
  assign is_attr = (rx_hdr.stream == trmh_pkg::STRM_CTL) &&
    ((rx_hdr.func == trmh_pkg::FN_ATTR_RD) || (rx_hdr.func == trmh_pkg::FN_ATTR_WR));

  // Supported function numbers within each handled stream
  always_comb begin
    fn_ok = 1'b0;
    if (rx_hdr.stream == trmh_pkg::STRM_MAT) begin
      fn_ok = (rx_hdr.func == trmh_pkg::FN_MID_RPT_ACK) || (rx_hdr.func == trmh_pkg::FN_DSP_WR);
    end else if (rx_hdr.stream == trmh_pkg::STRM_CTL) begin
      unique case (rx_hdr.func)
        trmh_pkg::FN_ATTR_RD, trmh_pkg::FN_ATTR_WR, trmh_pkg::FN_DATA_RD,
        trmh_pkg::FN_DATA_WR, trmh_pkg::FN_MID_RD, trmh_pkg::FN_MID_WR,
        trmh_pkg::FN_SUBSYS, trmh_pkg::FN_SCAN: fn_ok = 1'b1;
        default: fn_ok = 1'b0;
      endcase
    end
  end

  // Header of an outgoing material report
  always_comb begin
    mat_hdr = '0;
    mat_hdr.rbit = 1'b1;
    mat_hdr.dev_id = dev_id_r;
    mat_hdr.wbit = 1'b1;
    mat_hdr.stream = trmh_pkg::STRM_MAT;
    mat_hdr.func = trmh_pkg::FN_MID_RPT;
    mat_hdr.sys_bytes = seq_r;
  end

  // ==========================================================================
  // Message decode
  always_comb begin
    dec_send = 1'b0;
    dec_exec = 1'b0;
    dec_err = 1'b0;
    dec_cancel = 1'b0;
    dec_cmd = '0;
    dec_cmd.target = rx_body.target;
    dec_cmd.len = rx_body.len_value;
    dec_reply = '0;
    dec_reply.hdr = rx_hdr;
    dec_reply.hdr.rbit = 1'b1;
    dec_reply.hdr.dev_id = dev_id_r;
    dec_reply.hdr.wbit = 1'b0;
    dec_reply.hdr.func = rx_hdr.func + trmh_pkg::FN_STEP;
    dec_reply.offending_header = rx_hdr;
    dec_reply.ack = trmh_pkg::ACK_NORMAL;
    dec_reply.port = rx_body.target;
    if (rx_hdr.dev_id != dev_id_r) begin
      dec_err = 1'b1;
      dec_reply.hdr.func = trmh_pkg::FN_ERR_DEV;
    end else if (rx_hdr.func == trmh_pkg::FN_ABORT) begin
      dec_cancel = 1'b1;
    end else if (!strm_ok) begin
      dec_err = 1'b1;
      dec_reply.hdr.func = trmh_pkg::FN_ERR_STRM;
    end else if (!fn_ok) begin
      dec_err = 1'b1;
      dec_reply.hdr.func = trmh_pkg::FN_ERR_FUNC;
    end else if (!rx_body.ok || (is_attr && (rx_body.attr_n > trmh_pkg::ATTR_SLOTS_N))) begin
      dec_err = 1'b1;
      dec_reply.hdr.func = trmh_pkg::FN_ERR_DATA;
    end else if (rx_hdr.stream == trmh_pkg::STRM_MAT) begin
      if (rx_hdr.func == trmh_pkg::FN_MID_RPT_ACK) begin
        // Host acknowledge of our report ends the timed transaction
        dec_cancel = pending_r && (rx_hdr.sys_bytes == saved_hdr_r.sys_bytes);
      end else begin
        dec_exec = 1'b1;
        dec_cmd.op = trmh_pkg::OP_DISPLAY;
      end
    end else begin
      unique case (rx_hdr.func)
        trmh_pkg::FN_ATTR_RD: begin
          dec_exec = 1'b1;
          dec_cmd.op = trmh_pkg::OP_ATTR_RD;
          dec_reply.empty_slot = attr_unknown;
        end
        trmh_pkg::FN_ATTR_WR: begin
          dec_cmd.op = trmh_pkg::OP_ATTR_WR;
          if (|attr_unknown) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_COMM_ERR;
          end else begin
            dec_exec = 1'b1;
          end
        end
        trmh_pkg::FN_DATA_RD: begin
          dec_cmd.op = trmh_pkg::OP_DATA_RD;
          dec_cmd.mode.all_pages = !rx_body.seg_present && !rx_body.len_present;
          dec_cmd.mode.from_start = rx_body.seg_present && !rx_body.len_present;
          if (!tgt_ok) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_COMM_ERR;
          end else begin
            dec_exec = 1'b1;
          end
        end
        trmh_pkg::FN_DATA_WR: begin
          dec_cmd.op = trmh_pkg::OP_DATA_WR;
          dec_cmd.mode.all_pages = !rx_body.seg_present && !rx_body.len_present;
          dec_cmd.mode.whole_section = !rx_body.len_present ||
            (rx_body.len_value == '0);
          dec_cmd.mode.len_sets_size = !rx_body.seg_present && rx_body.len_present;
          if (!tgt_ok) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_COMM_ERR;
          end else if (rx_body.len_present && (rx_body.len_value != '0) &&
                       (rx_body.data_bytes > rx_body.len_value)) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_COMM_ERR;
          end else begin
            dec_exec = 1'b1;
          end
        end
        trmh_pkg::FN_MID_RD: begin
          dec_cmd.op = trmh_pkg::OP_MID_RD;
          if (!tgt_ok) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_COMM_ERR;
          end else begin
            dec_exec = 1'b1;
          end
        end
        trmh_pkg::FN_MID_WR: begin
          dec_cmd.op = trmh_pkg::OP_MID_WR;
          if (!tgt_ok) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_COMM_ERR;
          end else if (!maint_r) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_EQUIP_ERR;
          end else begin
            dec_exec = 1'b1;
          end
        end
        trmh_pkg::FN_SUBSYS: begin
          dec_exec = 1'b1;
          dec_cmd.op = trmh_pkg::OP_SUBSYS;
        end
        default: begin
          dec_cmd.op = trmh_pkg::OP_SCAN;
          if (!tgt_ok) begin
            dec_send = 1'b1;
            dec_reply.ack = trmh_pkg::ACK_COMM_ERR;
          end else begin
            dec_exec = 1'b1;
          end
        end
      endcase
    end
    // Error messages carry the offending header and want no reply
    if (dec_err) begin
      dec_send = 1'b1;
      dec_reply.hdr.stream = trmh_pkg::STRM_ERR;
    end else if (dec_send && !rx_hdr.wbit) begin
      dec_send = 1'b0;
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      trmh_pkg::ST_IDLE: begin
        if (take_rx) begin
          state_nxt = dec_exec ? trmh_pkg::ST_EXEC :
                      (dec_send ? trmh_pkg::ST_SEND : trmh_pkg::ST_IDLE);
        end else if (take_due || take_mat) begin
          state_nxt = trmh_pkg::ST_SEND;
        end
      end
      trmh_pkg::ST_EXEC: begin
        if (exec_done) begin
          state_nxt = want_r ? trmh_pkg::ST_SEND : trmh_pkg::ST_IDLE;
        end
      end
      trmh_pkg::ST_SEND: begin
        if (tx_ready) begin
          state_nxt = trmh_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // State and intake ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= trmh_pkg::ST_IDLE;
      rx_ready <= 1'b1;
      want_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rx_ready <= (state_nxt == trmh_pkg::ST_IDLE);
      if (take_rx) begin
        want_r <= rx_hdr.wbit;
      end
    end
  end

  // Engine command pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_start <= 1'b0;
      exec_cmd <= '0;
    end else begin
      exec_start <= take_rx && dec_exec;
      if (take_rx && dec_exec) begin
        exec_cmd <= dec_cmd;
      end
    end
  end

  // Outgoing message register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_msg <= '0;
      mat_ack <= 1'b0;
    end else begin
      mat_ack <= take_mat;
      if (take_rx) begin
        tx_msg <= dec_reply;
        tx_valid <= dec_send;
      end else if (take_due) begin
        tx_msg <= '0;
        tx_msg.hdr <= mat_hdr;
        tx_msg.hdr.wbit <= 1'b0;
        tx_msg.hdr.stream <= trmh_pkg::STRM_ERR;
        tx_msg.hdr.func <= trmh_pkg::FN_ERR_TMO;
        tx_msg.offending_header <= saved_hdr_r;
        tx_valid <= 1'b1;
      end else if (take_mat) begin
        tx_msg <= '0;
        tx_msg.hdr <= mat_hdr;
        tx_msg.port <= mat_port;
        tx_valid <= 1'b1;
      end else if ((state_r == trmh_pkg::ST_EXEC) && exec_done) begin
        tx_valid <= want_r;
        tx_msg.item_count <= exec_count;
        if ((exec_cmd.op == trmh_pkg::OP_SCAN) && (exec_count == '0)) begin
          tx_msg.ack <= trmh_pkg::ACK_NORMAL;
        end else begin
          tx_msg.ack <= exec_ack;
        end
      end else if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Reply timer, one millisecond tick
  assign tick = (tick_cnt_r == TICK_CYC - 1);
  // Only a taken cancel beats expiry; a stale header on the intake must not
  assign expire = pending_r && tick && (ms_cnt_r == REPLY_TIMEOUT_MS - 1) &&
    !(take_rx && dec_cancel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (tick || !pending_r) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Only the latest report is timed; a new one replaces it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_r <= 1'b0;
      saved_hdr_r <= '0;
      ms_cnt_r <= '0;
      seq_r <= '0;
    end else if (take_mat) begin
      pending_r <= 1'b1;
      saved_hdr_r <= mat_hdr;
      ms_cnt_r <= '0;
      seq_r <= seq_r + 32'h0000_0001;
    end else if (take_rx && dec_cancel) begin
      pending_r <= 1'b0;
    end else if (expire) begin
      pending_r <= 1'b0;
    end else if (pending_r && tick) begin
      ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
    end
  end

  // Timeout message owed, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      due_r <= 1'b0;
    end else if (expire) begin
      due_r <= 1'b1;
    end else if (take_due) begin
      due_r <= 1'b0;
    end
  end

  // Error statistics
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_r <= '0;
      tmo_cnt_r <= '0;
      last_err_r <= '0;
    end else if (take_rx && dec_err) begin
      err_cnt_r <= err_cnt_r + 16'h0001;
      last_err_r <= dec_reply.hdr.func;
    end else if (take_due) begin
      err_cnt_r <= err_cnt_r + 16'h0001;
      tmo_cnt_r <= tmo_cnt_r + 16'h0001;
      last_err_r <= trmh_pkg::FN_ERR_TMO;
    end
  end

  // ==========================================================================
  // APB slave, no wait states
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;

  // Read mux and address decode
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    unique case (paddr)
      trmh_pkg::OFS_CTRL: rd_data[trmh_pkg::CTRL_MT_BIT] = maint_r;
      trmh_pkg::OFS_DEVID: rd_data[14:0] = dev_id_r;
      trmh_pkg::OFS_LIMIT: begin
        rd_data[trmh_pkg::LIM_TGT_LSB +: 8] = tgt_max_r;
        rd_data[trmh_pkg::LIM_ATTR_LSB +: 8] = attr_max_r;
      end
      trmh_pkg::OFS_STATUS: begin
        rd_data[trmh_pkg::STAT_PEND_BIT] = pending_r;
        rd_data[trmh_pkg::STAT_DUE_BIT] = due_r;
        rd_data[trmh_pkg::STAT_BUSY_BIT] = (state_r != trmh_pkg::ST_IDLE);
        rd_data[trmh_pkg::STAT_LASTERR_LSB +: 8] = last_err_r;
      end
      trmh_pkg::OFS_COUNT: begin
        rd_data[trmh_pkg::CNT_ERR_LSB +: 16] = err_cnt_r;
        rd_data[trmh_pkg::CNT_TMO_LSB +: 16] = tmo_cnt_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pready <= 1'b1;
      prdata <= pwrite ? '0 : rd_data;
      pslverr <= !rd_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_r <= trmh_pkg::RST_MT;
      dev_id_r <= trmh_pkg::RST_DEVID;
      tgt_max_r <= trmh_pkg::RST_TGT_MAX;
      attr_max_r <= trmh_pkg::RST_ATTR_MAX;
    end else if (apb_wr) begin
      if (paddr == trmh_pkg::OFS_CTRL) begin
        maint_r <= pwdata[trmh_pkg::CTRL_MT_BIT];
      end
      if (paddr == trmh_pkg::OFS_DEVID) begin
        dev_id_r <= pwdata[14:0];
      end
      if (paddr == trmh_pkg::OFS_LIMIT) begin
        tgt_max_r <= pwdata[trmh_pkg::LIM_TGT_LSB +: 8];
        attr_max_r <= pwdata[trmh_pkg::LIM_ATTR_LSB +: 8];
      end
    end
  end

endmodule : trmh_core

// ===== testbench/trmh_core_props.sv
/* Port checker of the message handler.
   Bound into trmh_core; sees its ports only. */
`timescale 1ns/1ps
module trmh_core_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire trmh_pkg::trmh_hdr_t rx_hdr,
  input wire logic mat_ack,
  input wire logic exec_start,
  input wire logic tx_valid,
  input wire trmh_pkg::trmh_reply_t tx_msg,
  input wire logic tx_ready
);
  // ==========
  // Header of the last taken message
  trmh_pkg::trmh_hdr_t last_r;
  logic take;
  assign take = rx_valid && rx_ready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_r <= '0;
    else if (take)
      last_r <= rx_hdr;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Properties
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no pready");
  property p_unmap; psel && !penable && paddr > 12'h010 |=> pready && pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("no pslverr");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_msg); endproperty
  a_hold: assert property (p_hold) else $error("reply dropped");
  property p_busy; take && rx_hdr.wbit |=> !rx_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_strm;
    take && rx_hdr.func != 8'h00 && rx_hdr.stream != 7'h03 && rx_hdr.stream != 7'h12
      |=> tx_valid && tx_msg.hdr.stream == 7'h09;
  endproperty
  a_strm: assert property (p_strm) else $error("stream error missing");
  property p_offending_header;
    $rose(tx_valid) && tx_msg.hdr.stream == 7'h09 && tx_msg.hdr.func != 8'h09
      |-> tx_msg.offending_header == last_r;
  endproperty
  a_offending_header: assert property (p_offending_header) else $error("bad error header");
  property p_abort;
    take && rx_hdr.func == 8'h00 |=> !exec_start && (!tx_valid || tx_msg.hdr.func == 8'h01);
  endproperty
  a_abort: assert property (p_abort) else $error("abort acted on");
  property p_fn;
    $rose(tx_valid) && !tx_msg.hdr.wbit && tx_msg.hdr.stream != 7'h09
      |-> tx_msg.hdr.func == last_r.func + 8'h01 && tx_msg.hdr.stream == last_r.stream;
  endproperty
  a_fn: assert property (p_fn) else $error("bad reply function");
  property p_mat; mat_ack |-> ##[0:1] tx_valid && tx_msg.hdr.func == 8'h0d; endproperty
  a_mat: assert property (p_mat) else $error("no report");
  c_abort: cover property (take && rx_hdr.func == 8'h00);
  c_rpt: cover property (mat_ack);
  c_tmo: cover property (tx_valid && tx_msg.hdr.stream == 7'h09 && tx_msg.hdr.func == 8'h09);
endmodule : trmh_core_props
bind trmh_core trmh_core_props i_props (.*);

// ===== testbench/trmh_host_model.sv
/* Host model: takes each reply after one stall cycle.
   Assumes tx_valid is held until taken. */
`timescale 1ns/1ps
module trmh_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire trmh_pkg::trmh_reply_t tx_msg,
  output logic tx_ready,
  output logic got,
  output trmh_pkg::trmh_reply_t last
);
  // ==========
  // Ready after a wait cycle; capture on take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      got <= 1'b0;
      last <= '0;
    end else begin
      tx_ready <= tx_valid && !tx_ready;
      got <= tx_valid && tx_ready;
      if (tx_valid && tx_ready)
        last <= tx_msg;
    end
  end
endmodule : trmh_host_model

// ===== testbench/tag_reader_message_handler_tb_top.sv
/* Bench: registers, message decode, engine and reply timer.
   Bench plays parser and engine; host model takes replies. */
`timescale 1ns/1ps
module tag_reader_message_handler_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rx_valid = 1'b0, mat_req = 1'b0, exec_done = 1'b0, err, seen;
  logic pready, pslverr, rx_ready, mat_ack, exec_start, tx_valid, tx_ready, got;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] exec_ack = 16'h4f4b;
  logic [7:0] exec_count = 8'h01;
  trmh_pkg::trmh_hdr_t rx_hdr = '0;
  trmh_pkg::trmh_body_t rx_body = '0;
  trmh_pkg::trmh_exec_t exec_cmd;
  trmh_pkg::trmh_reply_t tx_msg, last;
  int n_fail = 0, compares = 0, cyc = 0;
  // ==========
  // Handler with short timer, host model, clock, engine, hang guard
  trmh_core #(.TICK_CYC(4), .REPLY_TIMEOUT_MS(3)) i_dut (.*, .mat_port(8'h02));
  trmh_host_model i_host (.*);
  always #10 pclk = ~pclk;
  always @(posedge pclk) exec_done <= exec_start;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Offer one message, check reply function and ack code
  task automatic msg(input logic [14:0] d, input logic [6:0] s, input logic [7:0] f,
      input logic [7:0] ef, input logic [15:0] ea);
    seen = 1'b0;
    rx_hdr <= {1'b0, d, f[0], s, f, 16'h0, 32'h7};
    rx_valid <= 1'b1;
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    repeat (12) begin
      @(posedge pclk);
      if (got === 1'b1) seen = 1'b1;
    end
    chk(seen === (ef != 8'h00) && (ef == 8'h00 || last.hdr.func === ef), "reply");
    if (ea != 16'h0) chk(last.ack === ea, "ack code");
  endtask : msg
  // Material report, held until taken
  task automatic rpt();
    mat_req <= 1'b1;
    do @(posedge pclk); while (mat_ack !== 1'b1);
    mat_req <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(last.hdr.func === 8'h0d && last.port === 8'h02, "report");
  endtask : rpt
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd === 32'h2001 && err === 1'b0, "limit reset");
    apb(1'b0, 12'h020, 32'h0);
    chk(err === 1'b1, "unmapped");
    $display("registers done");
    rx_body <= '{ok: 1'b1, target: 8'h01, attr_n: 4'h1, attr_id: 80'h30, default: '0};
    msg(15'h2, 7'h12, 8'h01, 8'h01, 16'h0);
    msg(15'h1, 7'h05, 8'h01, 8'h03, 16'h0);
    msg(15'h1, 7'h12, 8'h63, 8'h05, 16'h0);
    msg(15'h1, 7'h12, 8'h01, 8'h02, 16'h0);
    chk(last.empty_slot[0] === 1'b1, "empty slot");
    msg(15'h1, 7'h12, 8'h03, 8'h04, 16'h4345);
    msg(15'h1, 7'h12, 8'h09, 8'h0a, 16'h4f4b);
    msg(15'h1, 7'h12, 8'h0b, 8'h0c, 16'h4545);
    msg(15'h1, 7'h12, 8'h00, 8'h00, 16'h0);
    msg(15'h1, 7'h03, 8'h45, 8'h46, 16'h0);
    msg(15'h1, 7'h12, 8'h0d, 8'h0e, 16'h4f4b);
    rx_body <= '{ok: 1'b0, default: '0};
    msg(15'h1, 7'h12, 8'h01, 8'h07, 16'h0);
    rx_body <= '{ok: 1'b1, default: '0};
    msg(15'h1, 7'h12, 8'h01, 8'h02, 16'h0);
    msg(15'h1, 7'h12, 8'h05, 8'h06, 16'h4345);
    rx_body <= '{ok: 1'b1, target: 8'h01, default: '0};
    msg(15'h1, 7'h12, 8'h05, 8'h06, 16'h0);
    chk(exec_cmd.mode.all_pages === 1'b1, "read all pages");
    msg(15'h1, 7'h12, 8'h07, 8'h08, 16'h0);
    chk(exec_cmd.mode.whole_section === 1'b1, "write section");
    exec_count <= 8'h00;
    msg(15'h1, 7'h12, 8'h41, 8'h42, 16'h4e4f);
    chk(last.item_count === 8'h00, "empty scan");
    rx_body <= '{ok: 1'b1, target: 8'h01, len_present: 1'b1, len_value: 16'h4,
        data_bytes: 16'h8, default: '0};
    msg(15'h1, 7'h12, 8'h07, 8'h08, 16'h4345);
    apb(1'b1, 12'h000, 32'h1);
    msg(15'h1, 7'h12, 8'h0b, 8'h0c, 16'h4f4b);
    $display("decode done");
    rpt();
    msg(15'h1, 7'h03, 8'h00, 8'h00, 16'h0);
    repeat (20) @(posedge pclk);
    chk(last.hdr.stream === 7'h03, "cancelled wait");
    rpt();
    repeat (30) @(posedge pclk);
    chk(last.hdr.func === 8'h09 && last.offending_header.func === 8'h0d, "timeout");
    apb(1'b0, 12'h010, 32'h0);
    chk(rd === 32'h0001_0005 && err === 1'b0, "counts");
    $display("timer done");
    tally_and_finish();
  end
endmodule : tag_reader_message_handler_tb_top
